// ==== hw/dtc_cfg.svh ====
/*
 * Register offsets, field positions, reset values and fixed limits for the
 * single-channel transfer core. Assumes inclusion by bare name only.
 */
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ----------------------------------------
// Register offsets (word index on the port)
// ----------------------------------------
`define DTC_OFF_CTRL 3'h0
`define DTC_OFF_INT 3'h1
`define DTC_OFF_SRC 3'h2
`define DTC_OFF_DST 3'h3
`define DTC_OFF_CNT 3'h4
`define DTC_OFF_LIMH 3'h5
`define DTC_OFF_LIML 3'h6
`define DTC_OFF_WIN 3'h7

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DTC_CTL_EN 0
`define DTC_CTL_SIZE 1
`define DTC_CTL_TRM_LO 2
`define DTC_CTL_DAM_LO 4
`define DTC_CTL_SAM_LO 6
`define DTC_CTL_REQ 8
`define DTC_CTL_RELOAD 9
`define DTC_CTL_MASK 16'h03ff

// ----------------------------------------
// Interrupt control register fields
// ----------------------------------------
`define DTC_INT_HALF_WATERMARK_ENABLE 0
`define DTC_INT_OVR 3
`define DTC_INT_HALF 4
`define DTC_INT_DONE 5
`define DTC_INT_LOW 6
`define DTC_INT_HIGH 7
`define DTC_INT_SEL_LO 8
`define DTC_INT_BUFW 15
`define DTC_INT_WMASK 16'h7ff9

// ----------------------------------------
// Reset values and fixed figures
// ----------------------------------------
`define DTC_RST_WORD 16'h0000
`define DTC_RST_WINLO 11'h000
`define DTC_RST_WINHI 11'h000
`define DTC_RST_LIMH 16'hffff
`define DTC_SFR_TOP 16'h07ff

`endif

// ==== hw/dtc_pkg.sv ====
/*
 * Types shared by the transfer core: mode encodings, sequencer states and
 * the packed carriers of the data-side bus and the register port. Assumes the _cfg header.
 */
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_AM_FIXED = 2'h0,
        DTC_AM_INC = 2'h1,
        DTC_AM_DEC = 2'h2,
        DTC_AM_PIA = 2'h3
    } dtc_amode_t;

    typedef enum logic [1:0] {
        DTC_TM_ONESHOT = 2'h0,
        DTC_TM_REP_ONESHOT = 2'h1,
        DTC_TM_CONT = 2'h2,
        DTC_TM_REP_CONT = 2'h3
    } dtc_tmode_t;

    typedef enum logic [1:0] {
        DTC_ST_IDLE,
        DTC_ST_READ,
        DTC_ST_WRITE,
        DTC_ST_CHECK
    } dtc_state_t;

    // One bus cycle issued to peripherals or RAM
    typedef struct packed {
        logic rd;
        logic wr;
        logic byte_en;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dtc_mreq_t;

    // Register port request from the CPU side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [15:0] wdata;
    } dtc_rreq_t;

endpackage

// ==== hw/dtc_core.sv ====
/*
 * One channel of the memory transfer controller: registers, trigger
 * selection, read-then-write sequencing, address stepping and flags.
 * Assumes single-cycle data-side bus (read data in the cycle after rd),
 * triggers as one-cycle pulses synchronous to clk, and a CPU register port.
 */
`include "dtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dtc_core
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dtc_rreq_t reg_req,
    output logic [15:0] reg_rdata,
    input wire logic [127:0] hw_trig,
    output dtc_mreq_t mem_req,
    input wire logic [15:0] mem_rdata,
    output logic irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] m,
                                              input logic byte_sz);
        logic [15:0] d;
        d = byte_sz ? 16'h0001 : 16'h0002;
        case (m)
            DTC_AM_INC: step_addr = a + d;
            DTC_AM_DEC: step_addr = a - d;
            default: step_addr = a;
        endcase
        if (!byte_sz)
            step_addr[0] = 1'b0;
    endfunction

    function automatic logic [15:0] align(input logic [15:0] a, input logic byte_sz);
        align = byte_sz ? a : {a[15:1], 1'b0};
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    dtc_state_t state_r;
    logic [15:0] ctrl_r, intc_r, src_r, dst_r, cnt_r, limh_r, liml_r;
    logic [15:0] src0_r, dst0_r, cnt0_r, half_r, buf_r;
    logic [10:0] winlo_r, winhi_r;
    logic [15:0] reg_rdata_r;
    logic trig_q_r;
    logic irq_r;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic ch_en = ctrl_r[`DTC_CTL_EN];
    wire logic byte_sz = ctrl_r[`DTC_CTL_SIZE];
    wire logic [1:0] tmode = ctrl_r[`DTC_CTL_TRM_LO +: 2];
    wire logic [1:0] dmode = ctrl_r[`DTC_CTL_DAM_LO +: 2];
    wire logic [1:0] smode = ctrl_r[`DTC_CTL_SAM_LO +: 2];
    wire logic req_bit = ctrl_r[`DTC_CTL_REQ];
    wire logic reload_bit = ctrl_r[`DTC_CTL_RELOAD];
    wire logic repeated = tmode[0];
    wire logic continuous = tmode[1];
    wire logic [6:0] trig_sel = intc_r[`DTC_INT_SEL_LO +: 7];
    wire logic sel_trig = hw_trig[trig_sel];
    wire logic busy = (state_r != DTC_ST_IDLE);

    wire logic wr_ctrl = reg_req.wr && reg_req.addr == `DTC_OFF_CTRL;
    wire logic wr_int = reg_req.wr && reg_req.addr == `DTC_OFF_INT;
    wire logic wr_src = reg_req.wr && reg_req.addr == `DTC_OFF_SRC;
    wire logic wr_dst = reg_req.wr && reg_req.addr == `DTC_OFF_DST;
    wire logic wr_cnt = reg_req.wr && reg_req.addr == `DTC_OFF_CNT;

    wire logic [15:0] rd_addr = align(src_r, byte_sz);
    wire logic [15:0] wr_addr = align(dst_r, byte_sz);
    // Excluded window compared on the 11-bit space only
    wire logic in_window = (wr_addr[15:11] == 5'h00) &&
                           (wr_addr[10:0] >= winlo_r) &&
                           (wr_addr[10:0] <= winhi_r);

    // Byte lane pick for read data and placement for write data
    wire logic [7:0] rd_byte = rd_addr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
    wire logic [15:0] rd_val = byte_sz ? {8'h00, rd_byte} : mem_rdata;
    wire logic [15:0] wr_val = (byte_sz && wr_addr[0]) ? {buf_r[7:0], 8'h00} : buf_r;

    // Checks after access, on the addresses just used
    wire logic hi_viol = (rd_addr > limh_r) || (wr_addr > limh_r);
    wire logic lo_viol = ((rd_addr < liml_r) && (rd_addr > `DTC_SFR_TOP)) ||
                         ((wr_addr < liml_r) && (wr_addr > `DTC_SFR_TOP));

    wire logic [15:0] cnt_dec = cnt_r - 16'h0001;
    // Step and checks happen in CHECK, after the write used the unstepped destination
    wire logic reach_zero = (state_r == DTC_ST_CHECK) && (cnt_dec == 16'h0000);
    wire logic reach_half = (state_r == DTC_ST_CHECK) && (cnt_dec == half_r) &&
                            (half_r != 16'h0000);
    wire logic start_ok = ch_en && !busy && (req_bit || trig_q_r);
    wire logic overrun_ev = sel_trig && busy;
    wire logic more = continuous && !reach_zero && !hi_viol && !lo_viol;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    dtc_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DTC_ST_IDLE: if (start_ok) state_nxt = DTC_ST_READ;
            DTC_ST_READ: state_nxt = DTC_ST_WRITE;
            DTC_ST_WRITE: state_nxt = DTC_ST_CHECK;
            DTC_ST_CHECK: state_nxt = DTC_ST_IDLE;
            default: state_nxt = DTC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            state_r <= DTC_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Trigger latch: a trigger seen while busy is still served afterwards
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            trig_q_r <= 1'b0;
        else if (sel_trig && ch_en)
            trig_q_r <= 1'b1;
        else if (!ch_en || (state_r == DTC_ST_IDLE && start_ok))
            trig_q_r <= 1'b0;
    end

    // ----------------------------------------
    // Holding buffer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            buf_r <= `DTC_RST_WORD;
        else if (state_r == DTC_ST_WRITE)
            buf_r <= rd_val;
    end

    // Data-side bus: read issued in READ, data captured at WRITE edge
    wire logic issue_rd = (state_r == DTC_ST_READ);
    wire logic issue_wr = (state_r == DTC_ST_CHECK) && !in_window;
    assign mem_req.rd = issue_rd;
    assign mem_req.wr = issue_wr;
    assign mem_req.byte_en = byte_sz;
    assign mem_req.addr = issue_rd ? rd_addr : wr_addr;
    assign mem_req.wdata = wr_val;

    // ----------------------------------------
    // Control register: enable, request, fields
    // ----------------------------------------
    wire logic end_stop = (state_r == DTC_ST_CHECK) &&
                          ((reach_zero && !repeated) || hi_viol || lo_viol);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `DTC_RST_WORD;
        end else begin
            if (wr_ctrl)
                ctrl_r <= reg_req.wdata & `DTC_CTL_MASK;
            if (sel_trig && ch_en)
                ctrl_r[`DTC_CTL_REQ] <= 1'b1;
            else if (state_r == DTC_ST_CHECK && !more)
                ctrl_r[`DTC_CTL_REQ] <= 1'b0;
            if (end_stop)
                ctrl_r[`DTC_CTL_EN] <= 1'b0;
        end
    end

    // ----------------------------------------
    // Address and count registers
    // ----------------------------------------
    wire logic do_reload = reach_zero && (repeated || reload_bit);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_r <= `DTC_RST_WORD;
            dst_r <= `DTC_RST_WORD;
            cnt_r <= `DTC_RST_WORD;
            src0_r <= `DTC_RST_WORD;
            dst0_r <= `DTC_RST_WORD;
            cnt0_r <= `DTC_RST_WORD;
            half_r <= `DTC_RST_WORD;
        end else if (state_r == DTC_ST_CHECK) begin
            src_r <= do_reload ? src0_r : step_addr(src_r, smode, byte_sz);
            dst_r <= do_reload ? dst0_r : step_addr(dst_r, dmode, byte_sz);
            cnt_r <= do_reload ? cnt0_r : cnt_dec;
        end else begin
            if (wr_src) begin
                src_r <= reg_req.wdata;
                src0_r <= reg_req.wdata;
            end
            if (wr_dst) begin
                dst_r <= reg_req.wdata;
                dst0_r <= reg_req.wdata;
            end
            if (wr_cnt) begin
                cnt_r <= reg_req.wdata;
                cnt0_r <= reg_req.wdata;
                half_r <= {1'b0, reg_req.wdata[15:1]};
            end
        end
    end

    // ----------------------------------------
    // Limits and excluded window
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limh_r <= `DTC_RST_LIMH;
            liml_r <= `DTC_RST_WORD;
            winlo_r <= `DTC_RST_WINLO;
            winhi_r <= `DTC_RST_WINHI;
        end else if (reg_req.wr) begin
            if (reg_req.addr == `DTC_OFF_LIMH)
                limh_r <= reg_req.wdata;
            if (reg_req.addr == `DTC_OFF_LIML)
                liml_r <= reg_req.wdata;
            if (reg_req.addr == `DTC_OFF_WIN) begin
                winlo_r <= {3'h0, reg_req.wdata[7:0]};
                winhi_r <= {3'h7, reg_req.wdata[15:8]};
            end
        end
    end

    // ----------------------------------------
    // Interrupt control and status
    // ----------------------------------------
    wire logic done_ev = reach_zero;
    wire logic half_ev = reach_half;
    wire logic hi_ev = (state_r == DTC_ST_CHECK) && hi_viol;
    wire logic lo_ev = (state_r == DTC_ST_CHECK) && lo_viol;
    wire logic [15:0] hw_set = ({15'h0, 1'b0} |
                               ({15'h0, done_ev} << `DTC_INT_DONE) |
                               ({15'h0, half_ev} << `DTC_INT_HALF) |
                               ({15'h0, overrun_ev} << `DTC_INT_OVR) |
                               ({15'h0, hi_ev} << `DTC_INT_HIGH) |
                               ({15'h0, lo_ev} << `DTC_INT_LOW));
    wire logic buf_full_set = (state_r == DTC_ST_WRITE);
    wire logic buf_full_clr = (state_r == DTC_ST_CHECK);
    wire logic [15:0] intc_wr = reg_req.wdata & `DTC_INT_WMASK;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intc_r <= `DTC_RST_WORD;
        end else begin
            if (wr_int)
                intc_r <= intc_wr | hw_set;
            else
                intc_r <= intc_r | hw_set;
            if (buf_full_set)
                intc_r[`DTC_INT_BUFW] <= 1'b1;
            else if (buf_full_clr)
                intc_r[`DTC_INT_BUFW] <= 1'b0;
        end
    end

    // Interrupt pulses only on hardware events, never on writes
    wire logic irq_ev = done_ev || (half_ev && intc_r[`DTC_INT_HALF_WATERMARK_ENABLE]) ||
                        overrun_ev || hi_ev || lo_ev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            irq_r <= 1'b0;
        else
            irq_r <= irq_ev;
    end
    assign irq = irq_r;

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        case (reg_req.addr)
            `DTC_OFF_CTRL: rd_mux = ctrl_r;
            `DTC_OFF_INT: rd_mux = intc_r & 16'hfff9;
            `DTC_OFF_SRC: rd_mux = src_r;
            `DTC_OFF_DST: rd_mux = dst_r;
            `DTC_OFF_CNT: rd_mux = cnt_r;
            `DTC_OFF_LIMH: rd_mux = limh_r;
            `DTC_OFF_LIML: rd_mux = liml_r;
            default: rd_mux = {winhi_r[7:0], winlo_r[7:0]};
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata_r <= `DTC_RST_WORD;
        else
            reg_rdata_r <= reg_req.rd ? rd_mux : `DTC_RST_WORD;
    end
    assign reg_rdata = reg_rdata_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_xfer_rw;
        mem_req.rd ##1 (state_r == DTC_ST_WRITE) ##1 (state_r == DTC_ST_CHECK);
    endsequence

    a_read_then_write: assert property (@(posedge clk) disable iff (!rst_n)
        start_ok |=> s_xfer_rw)
        else $error("transfer did not run read then write");
    a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == DTC_ST_CHECK && !do_reload) |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("count did not drop by one");
    a_done_flag: assert property (@(posedge clk) disable iff (!rst_n)
        reach_zero |=> intc_r[`DTC_INT_DONE])
        else $error("done flag missing at zero count");
    a_oneshot_stop: assert property (@(posedge clk) disable iff (!rst_n)
        (reach_zero && !repeated) |=> !ch_en)
        else $error("channel not disabled at zero");
    a_window_nowr: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == DTC_ST_CHECK && in_window) |-> !mem_req.wr)
        else $error("bus cycle inside excluded window");
    a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
        intc_r[2:1] == 2'h0)
        else $error("unimplemented bits not zero");
    a_word_align: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_req.rd && !byte_sz) |-> !mem_req.addr[0])
        else $error("word address not aligned");
    a_sw_noirq: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_int && !irq_ev) |=> !irq)
        else $error("software write raised interrupt");
    a_overrun_set: assert property (@(posedge clk) disable iff (!rst_n)
        overrun_ev |=> intc_r[`DTC_INT_OVR])
        else $error("overrun flag not set");
    a_flag_wins: assert property (@(posedge clk) disable iff (!rst_n)
        (done_ev && wr_int) |=> intc_r[`DTC_INT_DONE])
        else $error("clear beat hardware set");

endmodule // dtc_core

`default_nettype wire

// ==== tb/dtc_mem_model.sv ====
/*
 * Behavioural data-side memory for the transfer core bench.
 * Assumes a single-cycle bus: read data stand only in the cycle after rd.
 */
`timescale 1ns/1ps
`default_nettype none

module dtc_mem_model
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire dtc_mreq_t mem_req,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [int];
    logic [15:0] data_r = 16'h0;
    logic valid_r = 1'b0;
    logic [15:0] w;
    logic [7:0] b;
    int idx;

    // Unwritten words hold a pattern made from their index
    function automatic logic [15:0] peek(input int i);
        return mem.exists(i) ? mem[i] : i[15:0] ^ 16'ha5c3;
    endfunction

    // Outside the answer cycle the lines show the inverse, never a stale copy
    assign mem_rdata = valid_r ? data_r : ~data_r;

    always @(posedge clk) begin
        idx = int'(mem_req.addr[15:1]);
        b = mem_req.addr[0] ? mem_req.wdata[15:8] : mem_req.wdata[7:0];
        valid_r <= mem_req.rd;
        if (mem_req.rd === 1'b1) begin
            data_r <= peek(idx);
        end
        if (mem_req.wr === 1'b1) begin
            w = peek(idx);
            w = mem_req.addr[0] ? {b, w[7:0]} : {w[15:8], b};
            mem[idx] = mem_req.byte_en ? w : mem_req.wdata;
        end
    end
endmodule // dtc_mem_model

`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the transfer core: register port tasks, a
 * reference model of addresses, data and flags, and the memory partner.
 * Assumes the design package and the memory model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import dtc_pkg::*;
;
    logic clk;
    logic rst_n;
    dtc_rreq_t reg_req;
    logic [15:0] reg_rdata;
    logic [127:0] hw_trig;
    dtc_mreq_t mem_req;
    logic [15:0] mem_rdata;
    logic irq;
    int bad_count = 0;
    int n_tests = 0;
    int irq_n = 0;
    logic [15:0] m_src;
    logic [15:0] m_dst;
    logic [15:0] ctl;
    logic [6:0] sel;
    logic [15:0] ref_mem [int];

    dtc_core u_dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .hw_trig(hw_trig), .mem_req(mem_req), .mem_rdata(mem_rdata), .irq(irq));
    dtc_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (irq === 1'b1) begin
            irq_n++;
        end
    end

    // ----
    // Helpers
    // ----
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
        @(posedge clk);
    endtask

    task automatic rchk(input logic [2:0] a, input logic [15:0] exp, input string what);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
        @(posedge clk);
        reg_req <= '0;
        #1;
        chk(reg_rdata, exp, what);
        @(posedge clk);
    endtask

    function automatic logic [15:0] rmem(input logic [15:0] a);
        return ref_mem.exists(int'(a[15:1])) ? ref_mem[int'(a[15:1])] : {1'b0, a[15:1]} ^ 16'ha5c3;
    endfunction

    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
        return m == 2'h1 ? a + (ctl[1] ? 16'h1 : 16'h2) : m == 2'h2 ? a - (ctl[1] ? 16'h1 : 16'h2) : a;
    endfunction

    task automatic pulse_trig();
        hw_trig <= 128'h1 << sel;
        @(posedge clk);
        hw_trig <= '0;
    endtask

    // ----
    // One read-then-write transfer against the reference model
    // ----
    task automatic xfer(input bit kick, input bit hw, input bit dowr, input bit ovr);
        int k;
        logic [15:0] w;
        logic [7:0] b;
        // Let the previous transfer reach idle, else the kick reads as overrun
        if (kick) @(posedge clk);
        if (kick && hw) pulse_trig();
        else if (kick) reg_wr(3'h0, ctl | 16'h0100);
        k = 0;
        #1;
        while (mem_req.rd !== 1'b1 && k < 60) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 60) begin
            bad_count++;
            $display("mismatch at %0t: no read cycle", $time);
            finish_test();
        end
        chk(mem_req.addr, m_src, "read address");
        w = rmem(m_src);
        b = m_src[0] ? w[15:8] : w[7:0];
        if (ovr) pulse_trig();
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (mem_req.wr !== 1'b1 && k < 3);
        chk({15'h0, mem_req.wr}, {15'h0, dowr}, "write strobe");
        if (dowr && ctl[1]) begin
            chk({8'h0, m_dst[0] ? mem_req.wdata[15:8] : mem_req.wdata[7:0]}, {8'h0, b}, "byte");
            w = rmem(m_dst);
            w = m_dst[0] ? {b, w[7:0]} : {w[15:8], b};
        end else if (dowr) begin
            chk(mem_req.wdata, w, "word data");
        end
        if (dowr) begin
            chk(mem_req.addr, m_dst, "write address");
            ref_mem[int'(m_dst[15:1])] = w;
        end
        m_src = step(m_src, ctl[7:6]);
        m_dst = step(m_dst, ctl[5:4]);
    endtask

    // ----
    // One programmed session of n transfers
    // ----
    task automatic session(input logic [1:0] tm, sm, dm, input logic sz, hen, input bit hw,
                           input int n);
        logic [15:0] s0;
        logic [15:0] d0;
        int i;
        s0 = (16'h1000 + 16'($urandom % 32'h3000)) & {15'h7fff, sz};
        d0 = (16'h8000 + 16'($urandom % 32'h3000)) & {15'h7fff, sz};
        sel = 7'($urandom % 128);
        // Trigger source changed only while the channel is idle
        reg_wr(3'h1, {1'b0, sel, 7'h0, hen});
        reg_wr(3'h2, s0);
        reg_wr(3'h3, d0);
        reg_wr(3'h4, 16'(n));
        ctl = {8'h0, sm, dm, tm, sz, 1'b1};
        reg_wr(3'h0, ctl);
        m_src = s0;
        m_dst = d0;
        irq_n = 0;
        for (i = 0; i < n; i++) xfer(i == 0 || !tm[1], hw, 1'b1, 1'b0);
        if (tm == 2'h3) reg_wr(3'h0, 16'h0);
        repeat (4) @(posedge clk);
        chk(16'(irq_n), 16'(1 + hen), "interrupt count");
        rchk(3'h1, {1'b0, sel, 8'h30 | 8'(hen)}, "flags");
        rchk(3'h0, tm == 2'h3 ? 16'h0 : {ctl[15:1], tm == 2'h1}, "control");
        if (tm != 2'h3) begin
            rchk(3'h4, tm[0] ? 16'(n) : 16'h0, "count");
            rchk(3'h2, tm[0] ? s0 : m_src, "source");
            rchk(3'h3, tm[0] ? d0 : m_dst, "destination");
        end
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        int i;
        int k;
        rst_n = 1'b0;
        reg_req = '0;
        hw_trig = '0;
        void'($urandom(32'h1b5adfa1));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 8; i++) rchk(3'(i), i == 5 ? 16'hffff : 16'h0, "reset value");
        irq_n = 0;
        reg_wr(3'h1, 16'hffff);
        rchk(3'h1, 16'h7ff9, "interrupt control");
        chk(16'(irq_n), 16'h0, "software flag interrupt");
        reg_wr(3'h1, 16'h0);
        rchk(3'h1, 16'h0, "flag clear");
        for (i = 0; i < 4; i++) session(2'(i), 2'(i + 1), 2'(3 * i + 1), i[0], ~i[0], ~i[0], i + 2);
        // Continuous run stopped by the upper limit, with an overrun on the way
        sel = 7'($urandom % 128);
        reg_wr(3'h1, {1'b0, sel, 8'h0});
        m_src = 16'h1000;
        m_dst = 16'h9000;
        reg_wr(3'h2, m_src);
        reg_wr(3'h3, m_dst);
        reg_wr(3'h4, 16'h8);
        reg_wr(3'h5, 16'h9004);
        ctl = 16'h0059;
        irq_n = 0;
        for (i = 0; i < 4; i++) xfer(i == 0, 1'b0, 1'b1, i == 1);
        k = 0;
        repeat (12) begin
            @(posedge clk);
            k += int'(mem_req.rd === 1'b1);
        end
        chk(16'(k), 16'h0, "read after limit");
        chk(16'(irq_n), 16'h2, "limit interrupts");
        rchk(3'h1, {1'b0, sel, 8'h98}, "limit flags");
        rchk(3'h0, 16'h0058, "limit control");
        // Destination inside the excluded window gets a read but no write
        reg_wr(3'h7, 16'h2010);
        m_src = 16'h1000;
        m_dst = 16'h0100;
        reg_wr(3'h2, m_src);
        reg_wr(3'h3, m_dst);
        reg_wr(3'h4, 16'h2);
        ctl = 16'h0001;
        xfer(1'b1, 1'b0, 1'b0, 1'b0);
        finish_test();
    end
endmodule // tb_top

`default_nettype wire
